// File: scdc_pkg.sv
package scdc_pkg;

  localparam int NCH = 6;

  // --------------------------------------------------------------------
  // Register map (byte addresses)
  // --------------------------------------------------------------------
  localparam logic [11:0] OFF_PREC = 12'h000;
  localparam logic [11:0] OFF_ESTEP0 = 12'h004;
  localparam logic [11:0] OFF_ESTEP1 = 12'h008;
  localparam logic [11:0] OFF_FSTEP0 = 12'h00c;
  localparam logic [11:0] OFF_FSTEP1 = 12'h010;
  // Channel n occupies the page paddr[11:8] = CH_PAGE_FIRST + n
  localparam logic [3:0] CH_PAGE_FIRST = 4'h1;
  localparam logic [3:0] CH_PAGE_LAST = 4'h6;
  // Word index paddr[5:2] inside a channel page
  localparam logic [3:0] CW_SRC = 4'h0;
  localparam logic [3:0] CW_DST = 4'h1;
  localparam logic [3:0] CW_CNT = 4'h2;
  localparam logic [3:0] CW_SYNF = 4'h3;
  localparam logic [3:0] CW_MODE = 4'h4;
  localparam logic [3:0] CW_RSRC = 4'h5;
  localparam logic [3:0] CW_RDST = 4'h6;
  localparam logic [3:0] CW_RCNT = 4'h7;
  localparam logic [3:0] CW_RFRM = 4'h8;

  localparam logic [15:0] PREC_RST = 16'h0000;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] SYNF_RST = 16'h0000;

  // --------------------------------------------------------------------
  // Codes
  // --------------------------------------------------------------------
  localparam logic [3:0] SYNC_NONE = 4'h0;
  localparam logic [3:0] SYNC_SER_LO = 4'h1;
  localparam logic [3:0] SYNC_SER_HI = 4'h6;
  localparam logic [3:0] SYNC_ABU_LO = 4'h7;
  localparam logic [3:0] SYNC_ABU_HI = 4'hc;
  localparam logic [3:0] SYNC_TIMER = 4'hd;
  localparam logic [3:0] SYNC_EXT3 = 4'he;
  localparam logic [3:0] SYNC_RSVD = 4'hf;

  localparam logic [1:0] ISEL_SERIAL = 2'h0;
  localparam logic [1:0] ISEL_CH23 = 2'h1;
  localparam logic [1:0] ISEL_CH0123 = 2'h2;

  typedef enum logic [2:0] {
    IDX_HOLD = 3'b000,
    IDX_INC = 3'b001,
    IDX_DEC = 3'b010,
    IDX_STEP0 = 3'b011,
    IDX_STEP1 = 3'b100
  } scdc_idx_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RD = 2'b01,
    ST_WR = 2'b10
  } scdc_state_t;

  typedef struct packed {
    logic free_run;
    logic per_channel_reload_select;
    logic [5:0] channel_priority_bits;
    logic [1:0] interrupt_line_select;
    logic [5:0] channel_enable_bits;
  } scdc_prec_t;

  typedef struct packed {
    logic auto_reload_enable;
    logic interrupt_enable_mode_bit;
    logic interrupt_mode_bit;
    logic doubleword;
    logic rsv_a;
    logic [2:0] source_index_select;
    logic [2:0] rsv_b;
    logic [2:0] destination_index_select;
    logic [1:0] rsv_c;
  } scdc_mode_t;

  typedef struct packed {
    logic [3:0] sync_event_select;
    logic [3:0] rsv;
    logic [7:0] frame_counter;
  } scdc_synf_t;

endpackage

// File: scdc_dma_ctrl.sv
`timescale 1ns/1ps
// Operation
// - Each channel high or low priority, round-robin.
// - Addresses hold, increment, decrement or step.
// - DMA addressing ignores processor memory mode bits.
// - Auto reload working registers after each block.
// - Reload registers sampled only at block end.
// - Reload set select picks channel 0 or own.
// - Eight-bit frame counter; zero means single frame.
// - Frame counter reloads at block end if auto.
// - Sixteen-bit element counter decrements per element read.
// - Element counter reloads at block end if auto.
// - Doubleword element is two 16-bit transfers.
// - Index selects choose one of two steps.
// - Last transfer of frame adds frame step.
// - Autobuffer interrupts at full, or half and full.
// - Multiframe interrupts at block, or every frame.
// - Four-bit sync select picks the trigger event.
// - All six channels raise interrupt requests; only channels 0 to 3 reach the CPU lines.
// - Line select routes shared interrupt lines.
// - Priority-enable register bit layout.
// - Block completion clears the channel enable bit unless auto reload is on.
module scdc_dma_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  input wire logic [5:0] serial_evt,
  input wire logic timer_evt,
  input wire logic ext3_evt,
  input wire logic serial2_receive_interrupt,
  input wire logic serial2_transmit_interrupt,
  input wire logic serial1_receive_interrupt,
  input wire logic serial1_transmit_interrupt,
  output logic [3:0] cpu_int_line,
  output logic [5:0] channel_int
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  scdc_pkg::scdc_prec_t prec_r;
  scdc_pkg::scdc_mode_t mode_r [6];
  scdc_pkg::scdc_synf_t synf_r [6];
  logic [15:0] src_r [6];
  logic [15:0] dst_r [6];
  logic [15:0] cnt_r [6];
  logic [15:0] einit_r [6];
  logic [15:0] rsrc_r [6];
  logic [15:0] rdst_r [6];
  logic [15:0] rcnt_r [6];
  logic [7:0] rfrm_r [6];
  logic [15:0] estep_r [2];
  logic [15:0] fstep_r [2];
  logic [5:0] pend_r;
  logic [2:0] rr_hi_r;
  logic [2:0] rr_lo_r;
  scdc_pkg::scdc_state_t st_r;
  logic [2:0] ch_r;
  logic half_r;
  logic last_r;
  logic blk_r;
  logic halfhit_r;
  logic [5:0] ch_int_r;
  logic [3:0] line_r;
  logic [31:0] prdata_r;

  logic [15:0] rd_val;
  logic unmapped;
  logic ch_hit;
  logic [2:0] ci;
  logic [3:0] cw;
  logic wr_en;
  logic [5:0] req;
  logic [5:0] hi_req;
  logic [5:0] lo_req;
  logic grant;
  logic [2:0] gch;
  logic rd_done;
  logic wr_done;
  logic fin;
  logic elem_done;
  logic last_now;
  logic [2:0] rsel;
  scdc_pkg::scdc_mode_t cur_mode;
  logic [15:0] cur_src;
  logic [15:0] cur_cnt;
  logic [7:0] cur_frm;
  logic [3:0] cur_sync;
  logic [7:0] evts;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  function automatic logic [2:0] rr_pick(input logic [5:0] m, input logic [2:0] last);
    logic [2:0] r;
    int k;
    r = 3'd0;
    for (int i = 6; i >= 1; i--) begin
      k = (int'(last) + i) % 6;
      if (m[k]) begin
        r = 3'(k);
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] adj(input logic [15:0] a, input logic [2:0] sel,
                                      input logic [15:0] s0, input logic [15:0] s1);
    case (sel)
      scdc_pkg::IDX_INC: adj = a + 16'h0001;
      scdc_pkg::IDX_DEC: adj = a - 16'h0001;
      scdc_pkg::IDX_STEP0: adj = a + s0;
      scdc_pkg::IDX_STEP1: adj = a + s1;
      default: adj = a;
    endcase
  endfunction

  function automatic logic evt_hit(input logic [3:0] code, input logic [7:0] ev);
    if (code >= scdc_pkg::SYNC_SER_LO && code <= scdc_pkg::SYNC_SER_HI) begin
      evt_hit = ev[3'(code - scdc_pkg::SYNC_SER_LO)];
    end else if (code >= scdc_pkg::SYNC_ABU_LO && code <= scdc_pkg::SYNC_ABU_HI) begin
      evt_hit = ev[3'(code - scdc_pkg::SYNC_ABU_LO)];
    end else if (code == scdc_pkg::SYNC_TIMER) begin
      evt_hit = ev[6];
    end else if (code == scdc_pkg::SYNC_EXT3) begin
      evt_hit = ev[7];
    end else begin
      evt_hit = 1'b0;
    end
  endfunction

  // ----------------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------------
  always_comb begin
    rd_val = 16'h0000;
    unmapped = 1'b0;
    ch_hit = 1'b0;
    ci = 3'(paddr[11:8] - scdc_pkg::CH_PAGE_FIRST);
    cw = paddr[5:2];
    case (paddr)
      scdc_pkg::OFF_PREC: rd_val = prec_r;
      scdc_pkg::OFF_ESTEP0: rd_val = estep_r[0];
      scdc_pkg::OFF_ESTEP1: rd_val = estep_r[1];
      scdc_pkg::OFF_FSTEP0: rd_val = fstep_r[0];
      scdc_pkg::OFF_FSTEP1: rd_val = fstep_r[1];
      default: begin
        ch_hit = paddr[11:8] >= scdc_pkg::CH_PAGE_FIRST && paddr[11:8] <= scdc_pkg::CH_PAGE_LAST &&
                 paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00 && cw <= scdc_pkg::CW_RFRM;
        unmapped = !ch_hit;
        if (ch_hit) begin
          case (cw)
            scdc_pkg::CW_SRC: rd_val = src_r[ci];
            scdc_pkg::CW_DST: rd_val = dst_r[ci];
            scdc_pkg::CW_CNT: rd_val = cnt_r[ci];
            scdc_pkg::CW_SYNF: rd_val = synf_r[ci];
            scdc_pkg::CW_MODE: rd_val = mode_r[ci];
            scdc_pkg::CW_RSRC: rd_val = rsrc_r[ci];
            scdc_pkg::CW_RDST: rd_val = rdst_r[ci];
            scdc_pkg::CW_RCNT: rd_val = rcnt_r[ci];
            default: rd_val = {8'h00, rfrm_r[ci]};
          endcase
        end
      end
    endcase
  end

  assign wr_en = psel && penable && pwrite && !unmapped;
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  assign prdata = prdata_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata_r <= {16'h0000, rd_val};
    end
  end

  // ----------------------------------------------------------------------
  // Priority and enable register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prec_r <= scdc_pkg::PREC_RST;
      estep_r[0] <= 16'h0000;
      estep_r[1] <= 16'h0000;
      fstep_r[0] <= 16'h0000;
      fstep_r[1] <= 16'h0000;
    end else begin
      if (wr_en && paddr == scdc_pkg::OFF_PREC) begin
        prec_r <= scdc_pkg::scdc_prec_t'(pwdata[15:0]);
      end
      if (wr_en && paddr == scdc_pkg::OFF_ESTEP0) estep_r[0] <= pwdata[15:0];
      if (wr_en && paddr == scdc_pkg::OFF_ESTEP1) estep_r[1] <= pwdata[15:0];
      if (wr_en && paddr == scdc_pkg::OFF_FSTEP0) fstep_r[0] <= pwdata[15:0];
      if (wr_en && paddr == scdc_pkg::OFF_FSTEP1) fstep_r[1] <= pwdata[15:0];
      // Hardware clear beats a racing software write so no stray transfer follows
      if (elem_done && blk_r && !cur_mode.auto_reload_enable) begin
        prec_r.channel_enable_bits[ch_r] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Synchronisation and arbitration
  // ----------------------------------------------------------------------
  assign evts = {ext3_evt, timer_evt, serial_evt};

  always_comb begin
    for (int i = 0; i < 6; i++) begin
      req[i] = prec_r.channel_enable_bits[i] &&
               (synf_r[i].sync_event_select == scdc_pkg::SYNC_NONE || pend_r[i]);
    end
  end

  assign hi_req = req & prec_r.channel_priority_bits;
  assign lo_req = req & ~prec_r.channel_priority_bits;
  assign grant = st_r == scdc_pkg::ST_IDLE && |req;
  assign gch = |hi_req ? rr_pick(hi_req, rr_hi_r) : rr_pick(lo_req, rr_lo_r);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        // An event in the take cycle is kept
        pend_r[i] <= evt_hit(synf_r[i].sync_event_select, evts) ||
                     (pend_r[i] && !(grant && gch == 3'(i)));
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rr_hi_r <= 3'd5;
      rr_lo_r <= 3'd5;
    end else if (grant) begin
      if (|hi_req) rr_hi_r <= gch;
      else rr_lo_r <= gch;
    end
  end

  // ----------------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------------
  assign cur_mode = mode_r[ch_r];
  assign cur_src = src_r[ch_r];
  assign cur_cnt = cnt_r[ch_r];
  assign cur_frm = synf_r[ch_r].frame_counter;
  assign cur_sync = synf_r[ch_r].sync_event_select;
  assign rd_done = st_r == scdc_pkg::ST_RD && mem_ack;
  assign wr_done = st_r == scdc_pkg::ST_WR && mem_ack;
  assign fin = !cur_mode.doubleword || half_r;
  assign elem_done = wr_done && fin;
  assign last_now = fin && cur_cnt == 16'h0000;
  assign rsel = prec_r.per_channel_reload_select ? ch_r : 3'd0;
  assign mem_req = st_r != scdc_pkg::ST_IDLE;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= scdc_pkg::ST_IDLE;
      ch_r <= 3'd0;
      half_r <= 1'b0;
      last_r <= 1'b0;
      blk_r <= 1'b0;
      halfhit_r <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 16'h0000;
      mem_wdata <= 16'h0000;
    end else begin
      case (st_r)
        scdc_pkg::ST_IDLE: begin
          if (grant) begin
            st_r <= scdc_pkg::ST_RD;
            ch_r <= gch;
            half_r <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= src_r[gch];
          end
        end
        scdc_pkg::ST_RD: begin
          if (mem_ack) begin
            st_r <= scdc_pkg::ST_WR;
            last_r <= last_now;
            blk_r <= last_now && cur_frm == 8'h00;
            halfhit_r <= fin && !last_now && cur_cnt == (einit_r[ch_r] >> 1);
            mem_we <= 1'b1;
            mem_addr <= dst_r[ch_r];
            mem_wdata <= mem_rdata;
          end
        end
        scdc_pkg::ST_WR: begin
          if (mem_ack) begin
            mem_we <= 1'b0;
            if (fin) begin
              st_r <= scdc_pkg::ST_IDLE;
            end else begin
              st_r <= scdc_pkg::ST_RD;
              half_r <= 1'b1;
              mem_addr <= cur_src;
            end
          end
        end
        default: st_r <= scdc_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Channel context: software writes, address and count updates
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 6; i++) begin
        mode_r[i] <= scdc_pkg::MODE_RST;
        synf_r[i] <= scdc_pkg::SYNF_RST;
        src_r[i] <= 16'h0000;
        dst_r[i] <= 16'h0000;
        cnt_r[i] <= 16'h0000;
        einit_r[i] <= 16'h0000;
        rsrc_r[i] <= 16'h0000;
        rdst_r[i] <= 16'h0000;
        rcnt_r[i] <= 16'h0000;
        rfrm_r[i] <= 8'h00;
      end
    end else begin
      if (rd_done) begin
        src_r[ch_r] <= adj(cur_src, cur_mode.source_index_select,
                           last_now ? fstep_r[0] : estep_r[0],
                           last_now ? fstep_r[1] : estep_r[1]);
        if (fin && cur_cnt != 16'h0000) begin
          cnt_r[ch_r] <= cur_cnt - 16'h0001;
        end else if (last_now && cur_frm != 8'h00) begin
          synf_r[ch_r].frame_counter <= cur_frm - 8'h01;
          cnt_r[ch_r] <= einit_r[ch_r];
        end
      end
      if (wr_done) begin
        dst_r[ch_r] <= adj(dst_r[ch_r], cur_mode.destination_index_select,
                           (fin && last_r) ? fstep_r[0] : estep_r[0],
                           (fin && last_r) ? fstep_r[1] : estep_r[1]);
      end
      if (elem_done && blk_r && cur_mode.auto_reload_enable) begin
        src_r[ch_r] <= rsrc_r[rsel];
        dst_r[ch_r] <= rdst_r[rsel];
        cnt_r[ch_r] <= rcnt_r[rsel];
        einit_r[ch_r] <= rcnt_r[rsel];
        synf_r[ch_r].frame_counter <= rfrm_r[rsel];
      end
      if (wr_en && ch_hit) begin
        case (cw)
          scdc_pkg::CW_SRC: src_r[ci] <= pwdata[15:0];
          scdc_pkg::CW_DST: dst_r[ci] <= pwdata[15:0];
          scdc_pkg::CW_CNT: begin
            cnt_r[ci] <= pwdata[15:0];
            einit_r[ci] <= pwdata[15:0];
          end
          scdc_pkg::CW_SYNF: synf_r[ci] <= scdc_pkg::scdc_synf_t'(pwdata[15:0]);
          scdc_pkg::CW_MODE: mode_r[ci] <= scdc_pkg::scdc_mode_t'(pwdata[15:0]);
          scdc_pkg::CW_RSRC: rsrc_r[ci] <= pwdata[15:0];
          scdc_pkg::CW_RDST: rdst_r[ci] <= pwdata[15:0];
          scdc_pkg::CW_RCNT: rcnt_r[ci] <= pwdata[15:0];
          default: rfrm_r[ci] <= pwdata[7:0];
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Channel interrupts and CPU line routing
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch_int_r <= 6'h00;
    end else begin
      ch_int_r <= 6'h00;
      if (elem_done && cur_mode.interrupt_enable_mode_bit) begin
        if (cur_sync >= scdc_pkg::SYNC_ABU_LO && cur_sync <= scdc_pkg::SYNC_ABU_HI) begin
          ch_int_r[ch_r] <= last_r || (cur_mode.interrupt_mode_bit && halfhit_r);
        end else begin
          ch_int_r[ch_r] <= cur_mode.interrupt_mode_bit ? last_r : blk_r;
        end
      end
    end
  end

  assign channel_int = ch_int_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_r <= 4'h0;
    end else begin
      case (prec_r.interrupt_line_select)
        scdc_pkg::ISEL_CH23: line_r <= {ch_int_r[3], ch_int_r[2], serial2_transmit_interrupt,
                                        serial2_receive_interrupt};
        scdc_pkg::ISEL_CH0123: line_r <= ch_int_r[3:0];
        default: line_r <= {serial1_transmit_interrupt, serial1_receive_interrupt,
                            serial2_transmit_interrupt, serial2_receive_interrupt};
      endcase
    end
  end

  assign cpu_int_line = line_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_first_half;
    wr_done && cur_mode.doubleword && !half_r;
  endsequence

  sequence s_second_read;
    st_r == scdc_pkg::ST_RD && half_r;
  endsequence

  hi_level_first_a: assert property (grant && |hi_req
                                     |=> prec_r.channel_priority_bits[ch_r] || $past(wr_en))
    else $error("low level granted while high pending");
  enable_clear_a: assert property (elem_done && blk_r && !cur_mode.auto_reload_enable
                                   |=> !prec_r.channel_enable_bits[$past(ch_r)])
    else $error("enable not cleared at block end");
  frame_reload_a: assert property (elem_done && blk_r && cur_mode.auto_reload_enable && !wr_en
                                   |=> synf_r[$past(ch_r)].frame_counter == $past(rfrm_r[rsel]))
    else $error("frame counter not reloaded");
  elem_dec_a: assert property (rd_done && fin && cur_cnt != 16'h0000 && !wr_en
                               |=> cnt_r[$past(ch_r)] == $past(cur_cnt) - 16'h0001)
    else $error("element counter not decremented");
  no_int_a: assert property (elem_done && !cur_mode.interrupt_enable_mode_bit |=> ch_int_r == 6'h00)
    else $error("interrupt raised while disabled");
  line_serial_a: assert property (prec_r.interrupt_line_select == scdc_pkg::ISEL_SERIAL
                                  |=> cpu_int_line == $past({serial1_transmit_interrupt, serial1_receive_interrupt,
                                                             serial2_transmit_interrupt, serial2_receive_interrupt}))
    else $error("shared lines not routed to serial ports");
  rsvd_sync_a: assert property (st_r == scdc_pkg::ST_IDLE ##1 st_r == scdc_pkg::ST_RD
                                |-> $past(synf_r[gch].sync_event_select) != scdc_pkg::SYNC_RSVD)
    else $error("reserved sync code started a transfer");
  dword_pair_a: assert property (s_first_half |=> s_second_read)
    else $error("second half of doubleword missing");
  frame_step_a: assert property (rd_done && last_now && !wr_en &&
                                 cur_mode.source_index_select == scdc_pkg::IDX_STEP0
                                 |=> src_r[$past(ch_r)] == $past(cur_src + fstep_r[0]))
    else $error("frame step not applied on last transfer");

endmodule // scdc_dma_ctrl

// File: scdc_mem_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Memory side: acks LAT+1 cycles after the request, logs writes
// ----------------------------------------
module scdc_mem_model #(
  parameter int LAT = 2
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  int cnt;
  logic [15:0] wa[$];
  logic [15:0] wd[$];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 16'h0000;
      cnt <= 0;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      cnt <= 0;
      mem_rdata <= ~mem_rdata;
      if (mem_we) begin
        wa.push_back(mem_addr);
        wd.push_back(mem_wdata);
      end
    end else begin
      // Read data is only meaningful with the ack; it toggles otherwise
      mem_rdata <= ~mem_rdata;
      if (mem_req && cnt >= LAT) begin
        mem_ack <= 1'b1;
        mem_rdata <= ~mem_addr;
      end
      if (mem_req) begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule // scdc_mem_model

// File: scdc_dma_ctrl_tb_top.sv
`timescale 1ns/1ps
module scdc_dma_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mem_req, mem_we, mem_ack, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] mem_addr, mem_wdata, mem_rdata;
  logic [3:0] s_int, cpu_int_line;
  logic [5:0] channel_int;
  int miscompares, n_checks, n_ci0, n_ci1, n_li0, n_li1;
  scdc_dma_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
    .serial_evt(6'h00), .timer_evt(1'b0), .ext3_evt(1'b0), .serial2_receive_interrupt(s_int[0]),
    .serial2_transmit_interrupt(s_int[1]), .serial1_receive_interrupt(s_int[2]),
    .serial1_transmit_interrupt(s_int[3]), .cpu_int_line(cpu_int_line), .channel_int(channel_int));
  scdc_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    n_ci0 += (channel_int[0] === 1'b1);
    n_ci1 += (channel_int[1] === 1'b1);
    n_li0 += (cpu_int_line[0] === 1'b1);
    n_li1 += (cpu_int_line[1] === 1'b1);
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      chk(32'h0, 32'h1, "apb timeout");
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run_ch(input logic [11:0] pg, input logic [15:0] s, input logic [15:0] d,
      input logic [15:0] c, input logic [15:0] f, input logic [15:0] md, input logic [15:0] prec);
    int i;
    mem_u.wa.delete();
    mem_u.wd.delete();
    n_ci0 = 0;
    n_ci1 = 0;
    n_li0 = 0;
    n_li1 = 0;
    apb(1'b1, pg, s);
    apb(1'b1, pg + 12'h004, d);
    apb(1'b1, pg + 12'h008, c);
    apb(1'b1, pg + 12'h00c, f);
    apb(1'b1, pg + 12'h010, md);
    apb(1'b1, scdc_pkg::OFF_PREC, prec);
    i = 0;
    do begin
      apb(1'b0, scdc_pkg::OFF_PREC, 16'h0000);
      i++;
    end while ((rd[5:0] & prec[5:0]) != 6'h00 && i < 200);
    chk({26'h0, rd[5:0] & prec[5:0]}, 32'h0, "enable not cleared");
    repeat (4) @(posedge pclk);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_regs;
    apb(1'b0, scdc_pkg::OFF_PREC, 16'h0000);
    chk(rd, {16'h0000, scdc_pkg::PREC_RST}, "prec reset");
    apb(1'b1, scdc_pkg::OFF_PREC, 16'hffc0);
    apb(1'b0, scdc_pkg::OFF_PREC, 16'h0000);
    chk(rd, 32'h0000ffc0, "prec fields");
    apb(1'b1, scdc_pkg::OFF_PREC, 16'h0000);
    apb(1'b0, 12'hffc, 16'h0000);
    chk({31'h0, er}, 32'h1, "unmapped");
    s_int <= 4'ha;
    repeat (3) @(posedge pclk);
    chk({28'h0, cpu_int_line}, 32'ha, "serial routing");
    s_int <= 4'h0;
    repeat (3) @(posedge pclk);
  endtask
  task automatic sc_single;
    run_ch(12'h100, 16'h0040, 16'h0200, 16'h0002, 16'h0000, 16'h4108, 16'h0081);
    chk(32'(mem_u.wa.size()), 32'h3, "element count");
    for (int k = 0; k < 3; k++) begin
      chk({mem_u.wa[k], mem_u.wd[k]}, {16'(16'h0200 - k), ~16'(16'h0040 + k)}, "inc dec");
    end
    chk(32'(n_ci0), 32'h1, "block int");
    chk(32'(n_li0), 32'h1, "line 6 routing");
  endtask
  task automatic sc_dword;
    run_ch(12'h200, 16'h0080, 16'h0300, 16'h0000, 16'h0001, 16'h7104, 16'h0042);
    chk(32'(mem_u.wa.size()), 32'h4, "two frames of halves");
    for (int k = 0; k < 4; k++) begin
      chk({mem_u.wa[k], mem_u.wd[k]}, {16'(16'h0300 + k), ~16'(16'h0080 + k)}, "dword");
    end
    chk(32'(n_ci1), 32'h2, "frame ints");
    chk(32'(n_li1), 32'h0, "line 7 serial");
  endtask
  task automatic sc_step;
    apb(1'b1, scdc_pkg::OFF_ESTEP0, 16'h0002);
    apb(1'b1, scdc_pkg::OFF_FSTEP0, 16'h0010);
    apb(1'b1, scdc_pkg::OFF_ESTEP1, 16'h0004);
    apb(1'b1, scdc_pkg::OFF_FSTEP1, 16'h0020);
    run_ch(12'h300, 16'h0040, 16'h0500, 16'h0001, 16'h0000, 16'h0310, 16'h0404);
    chk(32'(mem_u.wa.size()), 32'h2, "step count");
    chk({mem_u.wa[0], mem_u.wa[1]}, 32'h05000504, "element steps");
    chk({mem_u.wd[0], mem_u.wd[1]}, {~16'h0040, ~16'h0042}, "step data");
    apb(1'b0, 12'h300, 16'h0000);
    chk(rd, 32'h00000052, "src frame step");
    apb(1'b0, 12'h304, 16'h0000);
    chk(rd, 32'h00000524, "dst frame step");
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    s_int = 4'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    sc_regs();
    sc_single();
    sc_dword();
    sc_step();
    summarize();
  end
endmodule // scdc_dma_ctrl_tb_top
